// [backlight_config_fault_irq_regs.sv]
`timescale 1ns/1ps
module backlight_config_fault_irq_regs (
  // clock and synchronous reset
  input  wire logic                                 ref_clk,
  input  wire logic                                 rst_b,
  // register bus from the serial interface
  input  wire logic [backlight_regs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [backlight_regs_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  // fault inputs
  input  wire logic [7:0]                           fault_evt,
  input  wire logic [8:0]                           ext_fault_pending,
  // read answer and interrupt pin
  output logic      [backlight_regs_pkg::DATA_W-1:0] reg_rdata,
  output logic                                      reg_rvalid,
  output logic                                      fault_irq,
  // decoded configuration
  output backlight_regs_pkg::source_t               out5_source,
  output backlight_regs_pkg::source_t               out4_source,
  output logic      [2:0]                           dither_bits,
  output logic                                      thermal_monitor_on,
  output logic      [8:0]                           slope_time_ms,
  output logic                                      smooth_transition_on,
  output backlight_regs_pkg::dim_mode_t             dim_mode,
  output logic                                      min_pulse_skip_on,
  output logic      [7:0]                           pulse_floor_cycles
);
  import backlight_regs_pkg::*;

  // mapping codes to brightness sources
  // codes 2h and 3h both select cluster three
  function automatic source_t map_source(input logic [3:0] code);
    source_t src;
    src = SRC_DISPLAY;
    case (code)
      4'h0: src = SRC_DISPLAY;
      4'h1: src = SRC_CLUSTER1;
      4'h2: src = SRC_CLUSTER3;
      4'h3: src = SRC_CLUSTER3;
      4'h4: src = SRC_CLUSTER4;
      4'h5: src = SRC_CLUSTER5;
      // codes above 5 fall back to the display source
      default: src = SRC_DISPLAY;
    endcase
    return src;
  endfunction

  // address match for a write or read
  // offsets are compared in full, so aliases of a register read zero
  function automatic logic hit(
    input logic [9:0] addr,
    input logic [9:0] off
  );
    return addr == off;
  endfunction

  // plain read/write configuration words
  logic [15:0] led45_map_q;
  logic [15:0] dim_cfg_q;
  logic [15:0] pulse_cfg_q;

  // write strobes of the three plain words
  logic        map_wr;
  logic        dim_wr;
  logic        pulse_wr;

  // fields pulled from the words
  logic [3:0]  out5_source_sel;
  logic [3:0]  out4_source_sel;
  logic [2:0]  dither_code;
  logic [2:0]  slope_code;
  logic [1:0]  dim_code;

  // enables from the three enable registers
  // one bit per field, high while an enable field reads 2h; reserved fields give 0
  logic [7:0]  en_a;
  logic [7:0]  en_b;
  logic [7:0]  en_c;
  logic [7:0]  pair_gate;
  logic        flag_irq;
  logic        ext_irq;
  logic [8:0]  ext_gate;
  logic        irq_d;

  // read path
  // word picked by the offset of the current read
  logic [15:0] rdata_d;

  // one carrier per submodule register
  // the top keeps plain ports; only the submodules use the carrier
  reg_access_if en_a_bus ();
  reg_access_if en_b_bus ();
  reg_access_if en_c_bus ();
  reg_access_if flag_bus ();

  // write strobes to the submodule registers
  assign en_a_bus.wr    = reg_wr & hit(reg_addr, OFF_IRQ_EN_A);
  assign en_b_bus.wr    = reg_wr & hit(reg_addr, OFF_IRQ_EN_B);
  assign en_c_bus.wr    = reg_wr & hit(reg_addr, OFF_IRQ_EN_C);
  assign flag_bus.wr    = reg_wr & hit(reg_addr, OFF_FLAGS_A);
  assign en_a_bus.wdata = reg_wdata;
  assign en_b_bus.wdata = reg_wdata;
  assign en_c_bus.wdata = reg_wdata;
  assign flag_bus.wdata = reg_wdata;

  // write strobes to the plain words
  assign map_wr   = reg_wr & hit(reg_addr, OFF_LED45_MAP);
  assign dim_wr   = reg_wr & hit(reg_addr, OFF_DIM_CFG);
  assign pulse_wr = reg_wr & hit(reg_addr, OFF_PULSE_CFG);

  // enable fields read 0h or 2h; a write of 1h turns one off, 3h on
  // other codes are ignored, so a read-modify-write keeps the state
  // first enable layout
  irq_enable_reg #(
    .FIELD_MASK (EN_A_MASK),
    .RESET_VAL  (RST_IRQ_EN_A)
  ) u_en_a (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .bus     (en_a_bus.target),
    .enabled (en_a)
  );

  // only the LED pair is an enable; the rest is reserved storage
  // LED enable field
  irq_enable_reg #(
    .FIELD_MASK (EN_B_MASK),
    .RESET_VAL  (RST_IRQ_EN_B)
  ) u_en_b (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .bus     (en_b_bus.target),
    .enabled (en_b)
  );

  // every pair of the third register is an enable
  // third enable layout
  irq_enable_reg #(
    .FIELD_MASK (EN_C_MASK),
    .RESET_VAL  (RST_IRQ_EN_C)
  ) u_en_c (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .bus     (en_c_bus.target),
    .enabled (en_c)
  );

  // both temperature flags share one enable field
  // the reserved pair 9-8 never raises the pin
  // flag order follows the status word, highest pair first
  assign pair_gate = {
    en_a[OV_HIGH_FIELD],
    en_a[TEMP_FIELD],
    en_a[TEMP_FIELD],
    1'b0,
    en_a[3:0]
  };

  // status pairs; a fault in the clearing cycle keeps its flag
  fault_flag_reg #(
    .PAIR_MASK (FLAG_MASK)
  ) u_flags (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .bus       (flag_bus.target),
    .fault_evt (fault_evt),
    .pair_gate (pair_gate),
    .irq_req   (flag_irq)
  );

  // pending faults held in the other status registers
  // bit 8 is the LED open/short pair, bits 7-0 follow the third enables
  assign ext_gate = {en_b[LED_FIELD], en_c};
  assign ext_irq  = |(ext_fault_pending & ext_gate);

  // the global field gates flags held here and outside alike
  // enabled fault asserts pin
  assign irq_d = en_a[GLOBAL_FIELD] & (flag_irq | ext_irq);

  // the pin is registered, so it follows a fault or clear one edge late
  // a cleared flag drops the pin on the edge after the clearing write
  // the pin stays high while any enabled fault is still pending
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fault_irq <= 1'b0;
    end else begin
      fault_irq <= irq_d;
    end
  end

  // upper byte is reserved storage and reads back as written
  // output map word
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      led45_map_q <= RST_LED45_MAP;
    end else if (map_wr) begin
      led45_map_q <= reg_wdata;
    end
  end

  // dimming configuration word, reserved bits kept as storage
  // bits 12-10 reset to 2h and keep whatever the host writes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dim_cfg_q <= RST_DIM_CFG;
    end else if (dim_wr) begin
      dim_cfg_q <= reg_wdata;
    end
  end

  // pulse limit configuration word
  // only bit 15 has a meaning; the rest is kept for read-back
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pulse_cfg_q <= RST_PULSE_CFG;
    end else if (pulse_wr) begin
      pulse_cfg_q <= reg_wdata;
    end
  end

  // fields sliced from the stored words
  assign out5_source_sel = led45_map_q[OUT5_SEL_LSB +: SEL_W];
  assign out4_source_sel = led45_map_q[OUT4_SEL_LSB +: SEL_W];
  assign dither_code     = dim_cfg_q[DITHER_LSB +: 3];
  assign slope_code      = dim_cfg_q[SLOPE_LSB +: 3];
  assign dim_code        = dim_cfg_q[DIM_LSB +: 2];

  // both outputs share one decode function, each applied to its own select field
  // source decode
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      out5_source <= SRC_DISPLAY;
      out4_source <= SRC_DISPLAY;
    end else begin
      out5_source <= map_source(out5_source_sel);
      out4_source <= map_source(out4_source_sel);
    end
  end

  // dither depth
  // unused codes 6 and 7 leave dithering off
  // the depth goes out as a plain bit count
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dither_bits <= 3'h0;
    end else if (dither_code > DITHER_MAX) begin
      dither_bits <= 3'h0;
    end else begin
      dither_bits <= dither_code;
    end
  end

  // the monitor sits outside; only its enable is held here
  // thermal monitor enable
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      thermal_monitor_on <= 1'b0;
    end else begin
      thermal_monitor_on <= dim_cfg_q[THERMAL_BIT];
    end
  end

  // every slope code is legal, so the table needs no fallback
  // slope time lookup
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      slope_time_ms <= 9'h000;
    end else begin
      slope_time_ms <= SLOPE_MS_TABLE[slope_code];
    end
  end

  // advanced sloping stretches each transition and smooths it
  // sloping style
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      smooth_transition_on <= 1'b0;
    end else begin
      smooth_transition_on <= dim_cfg_q[SMOOTH_BIT];
    end
  end

  // the dimming engine reads the mode every cycle
  // dimming mode decode
  // unused code 2 falls back to plain PWM dimming
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dim_mode <= DIM_PWM;
    end else begin
      case (dim_code)
        DIM_CODE_HYB: dim_mode <= DIM_HYBRID;
        DIM_CODE_CC:  dim_mode <= DIM_CURRENT;
        default:      dim_mode <= DIM_PWM;
      endcase
    end
  end

  // pulse skip floor
  // the floor is zero while skipping is off so pulses stay untouched
  // the floor is rounded up to whole device clocks
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      min_pulse_skip_on  <= 1'b0;
      pulse_floor_cycles <= 8'h00;
    end else begin
      min_pulse_skip_on <= pulse_cfg_q[MIN_PWM_BIT];
      if (pulse_cfg_q[MIN_PWM_BIT]) begin
        pulse_floor_cycles <= 8'(MIN_PULSE_CYCLES);
      end else begin
        pulse_floor_cycles <= 8'h00;
      end
    end
  end

  // read mux; unmapped offsets read zero
  // a read in the same cycle as a write returns the old word
  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr)
      OFF_LED45_MAP: rdata_d = led45_map_q;
      OFF_DIM_CFG:   rdata_d = dim_cfg_q;
      OFF_PULSE_CFG: rdata_d = pulse_cfg_q;
      OFF_IRQ_EN_A:  rdata_d = en_a_bus.rdata;
      OFF_IRQ_EN_B:  rdata_d = en_b_bus.rdata;
      OFF_IRQ_EN_C:  rdata_d = en_c_bus.rdata;
      OFF_FLAGS_A:   rdata_d = flag_bus.rdata;
      default:       rdata_d = 16'h0000;
    endcase
  end

  // read data is captured once and held until the next read
  // rvalid pulses one cycle; rdata stays so a slow host can fetch it
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end
endmodule

// [backlight_regs_pkg.sv]
package backlight_regs_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int FIELDS = 8;

  // register byte offsets
  localparam logic [9:0] OFF_LED45_MAP = 10'h032;
  localparam logic [9:0] OFF_DIM_CFG   = 10'h040;
  localparam logic [9:0] OFF_PULSE_CFG = 10'h042;
  localparam logic [9:0] OFF_IRQ_EN_C  = 10'h04e;
  localparam logic [9:0] OFF_IRQ_EN_A  = 10'h050;
  localparam logic [9:0] OFF_IRQ_EN_B  = 10'h052;
  localparam logic [9:0] OFF_FLAGS_A   = 10'h054;

  // reset values
  localparam logic [15:0] RST_LED45_MAP = 16'h0000;
  localparam logic [15:0] RST_DIM_CFG   = 16'h08b0;
  localparam logic [15:0] RST_PULSE_CFG = 16'h0000;
  localparam logic [15:0] RST_IRQ_EN_C  = 16'h200a;
  localparam logic [15:0] RST_IRQ_EN_A  = 16'ha02a;
  localparam logic [15:0] RST_IRQ_EN_B  = 16'h0080;

  // field positions
  localparam int OUT5_SEL_LSB = 4;
  localparam int OUT4_SEL_LSB = 0;
  localparam int SEL_W        = 4;
  localparam int DITHER_LSB   = 13;
  localparam int THERMAL_BIT  = 9;
  localparam int SLOPE_LSB    = 5;
  localparam int SMOOTH_BIT   = 4;
  localparam int DIM_LSB      = 0;
  localparam int MIN_PWM_BIT  = 15;

  // two-bit field indices (field i = bits 2i+1:2i)
  localparam int GLOBAL_FIELD    = 7;
  localparam int OV_HIGH_FIELD   = 6;
  localparam int TEMP_FIELD      = 5;
  localparam int LED_FIELD       = 3;
  localparam logic [7:0] EN_A_MASK  = 8'hef;
  localparam logic [7:0] EN_B_MASK  = 8'h08;
  localparam logic [7:0] EN_C_MASK  = 8'hff;
  localparam logic [7:0] FLAG_MASK  = 8'hef;

  // enable field encodings
  localparam logic [1:0] EN_WR_OFF = 2'h1;
  localparam logic [1:0] EN_WR_ON  = 2'h3;
  localparam logic [1:0] EN_RD_ON  = 2'h2;
  localparam logic [1:0] EN_RD_OFF = 2'h0;

  // dither and dimming codes
  localparam logic [2:0] DITHER_MAX   = 3'h5;
  localparam logic [1:0] DIM_CODE_HYB = 2'h1;
  localparam logic [1:0] DIM_CODE_CC  = 2'h3;

  // slope times in ms, indexed by code
  localparam logic [7:0][8:0] SLOPE_MS_TABLE = {
    9'd500, 9'd300, 9'd200, 9'd100, 9'd50, 9'd2, 9'd1, 9'd0};

  // shortest pulse kept when skipping is on
  localparam int CLK_PERIOD_NS    = 8;
  localparam int MIN_PULSE_NS     = 200;
  localparam int MIN_PULSE_CYCLES =
    (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    SRC_DISPLAY, SRC_CLUSTER1, SRC_CLUSTER3,
    SRC_CLUSTER4, SRC_CLUSTER5
  } source_t;

  typedef enum logic [1:0] {
    DIM_PWM, DIM_HYBRID, DIM_CURRENT
  } dim_mode_t;
endpackage

// [reg_access_if.sv]
`timescale 1ns/1ps
// one register's write strobe, write data and read value
interface reg_access_if;
  logic        wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport owner  (output wr, output wdata, input rdata);
  modport target (input wr, input wdata, output rdata);
endinterface

// [irq_enable_reg.sv]
`timescale 1ns/1ps
// eight two-bit fields; masked ones use the split enable code
module irq_enable_reg
  import backlight_regs_pkg::*;
#(
  parameter logic [7:0]  FIELD_MASK = 8'hff,
  parameter logic [15:0] RESET_VAL  = 16'h0000
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  reg_access_if.target    bus,
  output logic [7:0]      enabled
);
  for (genvar i = 0; i < FIELDS; i++) begin : g_field
    logic [1:0] field_q;
    logic [1:0] wr_code;
    assign wr_code = bus.wdata[2*i+1 -: 2];
    if (FIELD_MASK[i]) begin : g_en
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          field_q <= RESET_VAL[2*i+1 -: 2];
        end else if (bus.wr && wr_code == EN_WR_ON) begin
          field_q <= EN_RD_ON;
        end else if (bus.wr && wr_code == EN_WR_OFF) begin
          field_q <= EN_RD_OFF;
        end
      end
      assign enabled[i] = field_q[1];
    end else begin : g_raw
      // reserved bits are plain storage
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          field_q <= RESET_VAL[2*i+1 -: 2];
        end else if (bus.wr) begin
          field_q <= wr_code;
        end
      end
      assign enabled[i] = 1'b0;
    end
    assign bus.rdata[2*i+1 -: 2] = field_q;
  end
endmodule

// [fault_flag_reg.sv]
`timescale 1ns/1ps
// sticky fault flags, each cleared by writing 1 to the flag bit and the bit just below it
module fault_flag_reg
  import backlight_regs_pkg::*;
#(
  parameter logic [7:0] PAIR_MASK = 8'hff
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  reg_access_if.target    bus,
  input  wire logic [7:0] fault_evt,
  input  wire logic [7:0] pair_gate,
  output logic            irq_req
);
  logic [7:0] pend;

  for (genvar i = 0; i < FIELDS; i++) begin : g_pair
    if (PAIR_MASK[i]) begin : g_flag
      logic flag_q;
      logic clr;
      assign clr = bus.wr & bus.wdata[2*i+1] & bus.wdata[2*i];
      // a fault in the clearing cycle wins, so it is never lost
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          flag_q <= 1'b0;
        end else if (fault_evt[i]) begin
          flag_q <= 1'b1;
        end else if (clr) begin
          flag_q <= 1'b0;
        end
      end
      assign bus.rdata[2*i+1 -: 2] = {flag_q, 1'b0};
      assign pend[i] = flag_q & pair_gate[i];
    end else begin : g_none
      assign bus.rdata[2*i+1 -: 2] = 2'h0;
      assign pend[i] = 1'b0;
    end
  end

  assign irq_req = |pend;
endmodule

// [backlight_regs_properties.sv]
`timescale 1ns/1ps
// port-level checks of the register slice
module backlight_regs_properties
  import backlight_regs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [9:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  fault_evt,
  input wire logic [8:0]  ext_fault_pending,
  input wire logic [15:0] reg_rdata,
  input wire logic        fault_irq,
  input wire source_t     out5_source,
  input wire logic [2:0]  dither_bits,
  input wire logic        thermal_monitor_on,
  input wire logic [8:0]  slope_time_ms,
  input wire dim_mode_t   dim_mode,
  input wire logic        min_pulse_skip_on
);
  logic global_on_q;
  logic cfg_wr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // dimming config write seen at the port
  assign cfg_wr = reg_wr && reg_addr == OFF_DIM_CFG;

  // shadow of the global gate; codes 0 and 2 leave it alone
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      global_on_q <= 1'b1;
    end else if (reg_wr && reg_addr == OFF_IRQ_EN_A && reg_wdata[14]) begin
      global_on_q <= reg_wdata[15];
    end
  end

  map_code_a: assert property (
    reg_wr && reg_addr == OFF_LED45_MAP && reg_wdata[7:4] == 4'h3
    |-> ##2 out5_source == SRC_CLUSTER3) else $error("output 5 source wrong");
  dither_unused_a: assert property (
    cfg_wr && reg_wdata[15:13] > 3'h5 |-> ##2 dither_bits == 3'h0)
    else $error("unused dither code not off");
  thermal_bit_a: assert property (
    cfg_wr |-> ##2 thermal_monitor_on == $past(reg_wdata[9], 2))
    else $error("thermal monitor bit wrong");
  slope_code_a: assert property (
    cfg_wr && reg_wdata[7:5] == 3'h3 |-> ##2 slope_time_ms == 9'd50)
    else $error("slope time wrong");
  dim_current_a: assert property (
    cfg_wr && reg_wdata[1:0] == 2'h3 |-> ##2 dim_mode == DIM_CURRENT)
    else $error("dimming mode wrong");
  pulse_skip_a: assert property (
    reg_wr && reg_addr == OFF_PULSE_CFG |-> ##2 min_pulse_skip_on == $past(reg_wdata[15], 2))
    else $error("pulse skip bit wrong");
  enable_read_a: assert property (
    reg_rd && (reg_addr == OFF_IRQ_EN_A || reg_addr == OFF_IRQ_EN_C)
    |=> (reg_rdata & 16'h5455) == 16'h0000) else $error("enable field read odd");
  flag_read_a: assert property (
    reg_rd && reg_addr == OFF_FLAGS_A |=> (reg_rdata & 16'h5755) == 16'h0000)
    else $error("clear or reserved bit read set");
  clear_all_a: assert property (
    (reg_wr && reg_addr == OFF_FLAGS_A && reg_wdata == 16'hffff && fault_evt == 8'h00
     && ext_fault_pending == 9'h000) ##1 (ext_fault_pending == 9'h000) |=> !fault_irq)
    else $error("pin still high after clear");
  global_gate_a: assert property (
    !global_on_q && !$past(global_on_q) |-> !fault_irq)
    else $error("pin high with global gate off");
endmodule

bind backlight_config_fault_irq_regs backlight_regs_properties props (.*);

// [backlight_host_model.sv]
`timescale 1ns/1ps
// host side of the register bus; the bench calls its tasks
module backlight_host_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output logic      [9:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  int timeouts = 0;

  // bus idle from time zero
  initial begin
    reg_addr = 10'h000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // stale data must not look valid
  endtask

  // read waits a bounded time for the valid pulse
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 4) timeouts++;
    d = reg_rdata;
  endtask
endmodule

// [backlight_config_fault_irq_regs_bench.sv]
`timescale 1ns/1ps
module backlight_config_fault_irq_regs_bench;
  import backlight_regs_pkg::*;
  typedef struct packed {logic wr; logic [9:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [9:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, reg_rvalid, fault_irq;
  logic [7:0]  fault_evt = 8'h00;
  logic [8:0]  ext_fault_pending = 9'h000;
  source_t     out5_source, out4_source;
  logic [2:0]  dither_bits;
  logic [8:0]  slope_time_ms;
  dim_mode_t   dim_mode;
  logic        thermal_monitor_on, smooth_transition_on, min_pulse_skip_on;
  logic [7:0]  pulse_floor_cycles;
  logic [2:0]  c;
  int          error_cnt = 0;
  int          n_checks = 0;
  logic [8:0]  ms [8] = '{9'd0, 9'd1, 9'd2, 9'd50, 9'd100, 9'd200, 9'd300, 9'd500};
  // reset reads first, then writes with their read-back
  row_t rows [19] = '{
    '{1'b0, 10'h032, 16'h0000, 16'h0000}, '{1'b0, 10'h040, 16'h0000, 16'h08b0},
    '{1'b0, 10'h042, 16'h0000, 16'h0000}, '{1'b0, 10'h04e, 16'h0000, 16'h200a},
    '{1'b0, 10'h050, 16'h0000, 16'ha02a}, '{1'b0, 10'h052, 16'h0000, 16'h0080},
    '{1'b0, 10'h054, 16'h0000, 16'h0000}, '{1'b1, 10'h032, 16'hff54, 16'hff54},
    '{1'b1, 10'h040, 16'hbef3, 16'hbef3}, '{1'b1, 10'h042, 16'h8000, 16'h8000},
    '{1'b1, 10'h050, 16'h5555, 16'h0100}, '{1'b1, 10'h050, 16'hfeff, 16'haaaa},
    '{1'b1, 10'h050, 16'h0000, 16'ha8aa}, '{1'b1, 10'h050, 16'haaaa, 16'haaaa},
    '{1'b1, 10'h04e, 16'h5555, 16'h0000}, '{1'b1, 10'h04e, 16'hffff, 16'haaaa},
    '{1'b1, 10'h052, 16'hff7f, 16'hff3f}, '{1'b1, 10'h052, 16'h00c0, 16'h0080},
    '{1'b1, 10'h054, 16'hffff, 16'h0000}};

  // free-running device clock
  always #4 ref_clk = ~ref_clk;

  backlight_host_model host (.*);
  backlight_config_fault_irq_regs dut (.*);

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  task automatic rchk(input logic [9:0] a, input logic [15:0] e);
    logic [15:0] got;
    host.rd(a, got);
    chk($sformatf("reg %h", a), e, got);
  endtask

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic pulse(input int i);
    @(posedge ref_clk);
    fault_evt[i] <= 1'b1;
    @(posedge ref_clk);
    fault_evt <= 8'h00;
    settle();
  endtask

  task automatic conclude();
    error_cnt += host.timeouts;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    settle();
    chk("slope reset", 16'd200, {7'h0, slope_time_ms});
    for (int i = 0; i < 19; i++) begin
      if (rows[i].wr) host.wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    chk("skip", {7'h0, 1'b1, 8'd25}, {7'h0, min_pulse_skip_on, pulse_floor_cycles});
    chk("src", {10'h0, SRC_CLUSTER5, SRC_CLUSTER4}, {10'h0, out5_source, out4_source});
    host.wr(10'h032, 16'h0032);
    settle();
    chk("src", {10'h0, SRC_CLUSTER3, SRC_CLUSTER3}, {10'h0, out5_source, out4_source});
    host.wr(10'h032, 16'h0061);
    settle();
    chk("src", {10'h0, SRC_DISPLAY, SRC_CLUSTER1}, {10'h0, out5_source, out4_source});
    // every code of the dimming config fields in one sweep
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      host.wr(10'h040, {c, 3'h0, c[0], 1'b0, c, c[1], 2'h0, c[1:0]});
      settle();
      chk("dim cfg", {(c > 3'h5) ? 3'h0 : c, c[0], ms[k], c[1],
        (c[1:0] == 2'h3) ? DIM_CURRENT : (c[1:0] == 2'h1) ? DIM_HYBRID : DIM_PWM},
        {dither_bits, thermal_monitor_on, slope_time_ms,
        smooth_transition_on, dim_mode});
    end
    pulse(0);
    chk("irq", 16'h1, {15'h0, fault_irq});
    rchk(10'h054, 16'h0002);
    host.wr(10'h054, 16'h0002);
    host.wr(10'h054, 16'h0001);
    settle();
    chk("irq", 16'h1, {15'h0, fault_irq});
    rchk(10'h054, 16'h0002);
    host.wr(10'h054, 16'h0003);
    settle();
    chk("irq", 16'h0, {15'h0, fault_irq});
    rchk(10'h054, 16'h0000);
    host.wr(10'h050, 16'h1000);
    pulse(7);
    chk("irq", 16'h0, {15'h0, fault_irq});
    rchk(10'h054, 16'h8000);
    host.wr(10'h054, 16'hc000);
    host.wr(10'h050, 16'h4000);
    host.wr(10'h050, 16'h3000);
    pulse(7);
    ext_fault_pending <= 9'h100;
    settle();
    chk("irq", 16'h0, {15'h0, fault_irq});
    host.wr(10'h050, 16'hc000);
    settle();
    chk("irq", 16'h1, {15'h0, fault_irq});
    host.wr(10'h054, 16'hc000);
    settle();
    chk("irq", 16'h1, {15'h0, fault_irq});
    // a fault in the clearing cycle keeps its flag
    pulse(1);
    fork
      host.wr(10'h054, 16'h000c);
      pulse(1);
    join
    rchk(10'h054, 16'h0008);
    ext_fault_pending <= 9'h000;
    host.wr(10'h054, 16'hffff);
    settle();
    chk("irq", 16'h0, {15'h0, fault_irq});
    // second reset in mid-run restores the config value
    host.wr(10'h040, 16'h0000);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    rchk(10'h040, 16'h08b0);
    chk("slope reset", 16'd200, {7'h0, slope_time_ms});
    conclude();
  end
endmodule
